//--- bench/clkdiv_ctrl_tb_top.sv
// clkdiv_ctrl_tb_top: register tests of the divider and apply control.
// assumes clkdiv_pkg and the host model are compiled first.
`timescale 1ns/1ps
module clkdiv_ctrl_tb_top;
    import clkdiv_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [1:0] bresp, rresp;
    logic pre, four, five, busy;
    int err_total;
    int checks;
    bit busy_seen;
    always #5 clk = ~clk;
    clkdiv_ctrl i_dut (
        .SYS_CLK_I(clk), .RST_I(rst),
        .AWVALID_I(awvalid), .AWREADY_O(awready), .AWADDR_I(awaddr),
        .WVALID_I(wvalid), .WREADY_O(wready), .WDATA_I(wdata), .WSTRB_I(4'hf),
        .BVALID_O(bvalid), .BREADY_I(bready), .BRESP_O(bresp),
        .ARVALID_I(arvalid), .ARREADY_O(arready), .ARADDR_I(araddr),
        .RVALID_O(rvalid), .RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rresp),
        .REFERENCE_PREDIVIDER_O(pre), .SYSTEM_CLOCK_FOUR_O(four),
        .SYSTEM_CLOCK_FIVE_O(five), .APPLY_IN_PROGRESS_O(busy)
    );
    clkdiv_host_model i_host (
        .clk_i(clk), .awvalid_o(awvalid), .awready_i(awready), .awaddr_o(awaddr),
        .wvalid_o(wvalid), .wready_i(wready), .wdata_o(wdata),
        .bready_o(bready), .bvalid_i(bvalid),
        .arvalid_o(arvalid), .arready_i(arready), .araddr_o(araddr),
        .rready_o(rready), .rvalid_i(rvalid), .rdata_i(rdata), .rresp_i(rresp)
    );
    // remember any apply activity
    always @(negedge clk) if (busy === 1'b1) busy_seen = 1;
    // a stuck bus ends the run
    always @(posedge i_host.hung) begin
        err_total++;
        conclude();
    end
    task automatic conclude();
        if (err_total == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    // register read against expected word
    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        i_host.rd(a, d, r);
        cmp($sformatf("reg %h", a), e, d);
    endtask : rchk
    // pulse spacing of one strobe, first period skipped; 0 means stopped
    task automatic meas(input int s, input int e);
        int n;
        int p;
        int k;
        logic t;
        p = 0;
        k = 0;
        for (n = 0; n < 80 && k < 3; n++) begin
            @(negedge clk);
            t = (s == 0) ? pre : (s == 1) ? four : five;
            if (k == 2) p++;
            if (t === 1'b1) k++;
        end
        if (k < 3) p = 0;
        cmp($sformatf("period of strobe %0d", s), e, p);
    endtask : meas
    // command write, then bounded wait for apply to finish
    task automatic go(input logic [31:0] v, input logic e);
        int n;
        busy_seen = 0;
        rchk(ADDR_GO_STAT, 32'h0);
        i_host.wr(ADDR_GO_CMD, v);
        for (n = 0; n < 100; n++) begin
            @(negedge clk);
            if (busy !== 1'b1) break;
        end
        if (n == 100) begin
            err_total++;
            conclude();
        end else begin
            cmp("apply seen", {31'h0, e}, {31'h0, busy_seen});
        end
    endtask : go
    // main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        err_total = 0;
        checks = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // reset values
        rchk(ADDR_REFERENCE_PREDIVIDER, 32'h0000_8002);
        rchk(ADDR_DIV4, 32'h0000_8003);
        rchk(ADDR_DIV5, 32'h0000_8003);
        rchk(ADDR_GO_CMD, 32'h0);
        meas(0, 3);
        meas(1, 8);
        meas(2, 4);
        // every legal pre-divider code, reserved bits written as ones
        for (int i = 0; i < 3; i++) begin
            i_host.wr(ADDR_REFERENCE_PREDIVIDER, 32'hffff_ffe0 | 32'(i));
            rchk(ADDR_REFERENCE_PREDIVIDER, 32'h8000 | 32'(i));
            meas(0, i + 1);
        end
        i_host.wr(ADDR_REFERENCE_PREDIVIDER, 32'h0000_0002);
        meas(0, 0);
        i_host.wr(ADDR_REFERENCE_PREDIVIDER, 32'h0000_8002);
        meas(0, 3);
        // new divider five ratio waits for apply
        i_host.wr(ADDR_DIV5, 32'h0000_8001);
        rchk(ADDR_CHANGED, 32'h10);
        meas(2, 4);
        go(32'h1, 1'b1);
        rchk(ADDR_CHANGED, 32'h0);
        rchk(ADDR_GO_STAT, 32'h0);
        rchk(ADDR_GO_CMD, 32'h1);
        meas(2, 2);
        meas(1, 8);
        // divider four code 7 (period 16), apply with bit already set
        i_host.wr(ADDR_DIV4, 32'h0000_8007);
        rchk(ADDR_CHANGED, 32'h08);
        go(32'h1, 1'b1);
        meas(1, 16);
        meas(2, 2);
        go(32'h0, 1'b0);
        rchk(ADDR_GO_CMD, 32'h0);
        // divider five enable change needs no apply and sets no changed flag
        i_host.wr(ADDR_DIV5, 32'h0000_0001);
        rchk(ADDR_CHANGED, 32'h0);
        meas(2, 0);
        i_host.wr(ADDR_DIV5, 32'h0000_8001);
        meas(2, 2);
        // read-only flags ignore writes, unmapped write refused
        i_host.wr(ADDR_CHANGED, 32'hffff_ffff);
        cmp("changed write resp", {30'h0, RESP_OKAY}, {30'h0, bresp});
        rchk(ADDR_CHANGED, 32'h0);
        i_host.wr(32'h029a_0100, 32'h0000_8001);
        cmp("unmapped write resp", {30'h0, RESP_DECERR}, {30'h0, bresp});
        // unmapped place
        i_host.rd(32'h029a_0100, d, r);
        cmp("unmapped resp", {30'h0, RESP_DECERR}, {30'h0, r});
        cmp("unmapped data", 32'h0, d);
        conclude();
    end
endmodule : clkdiv_ctrl_tb_top

//--- bench/clkdiv_host_model.sv
// clkdiv_host_model: axi4-lite master in the processor's place.
// assumes one slave; every wait is bounded and flags hung.
`timescale 1ns/1ps
module clkdiv_host_model (
    // clock
    input wire logic clk_i,
    // write channels
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] awaddr_o,
    output logic wvalid_o,
    input wire logic wready_i,
    output logic [31:0] wdata_o,
    output logic bready_o,
    input wire logic bvalid_i,
    // read channels
    output logic arvalid_o,
    input wire logic arready_i,
    output logic [31:0] araddr_o,
    output logic rready_o,
    input wire logic rvalid_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i
);
    bit hung; // a wait ran out
    // idle bus at time zero
    initial begin
        {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
        {awaddr_o, wdata_o, araddr_o} = '0;
    end
    // one write; callers keep reserved codes out and wait out busy
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bit aw_hs;
        bit w_hs;
        bit b_hs;
        int n;
        @(posedge clk_i);
        awaddr_o <= a;
        wdata_o <= d;
        {awvalid_o, wvalid_o, bready_o} <= 3'b111;
        for (n = 0; n < 200; n++) begin
            // handshakes seen mid-cycle take effect at the next edge
            @(negedge clk_i);
            aw_hs = awvalid_o && awready_i;
            w_hs = wvalid_o && wready_i;
            b_hs = bready_o && bvalid_i;
            @(posedge clk_i);
            if (aw_hs) awvalid_o <= 1'b0;
            if (w_hs) wvalid_o <= 1'b0;
            if (b_hs) bready_o <= 1'b0;
            if (b_hs) break;
        end
        if (n == 200) hung = 1;
    endtask : wr
    // one read, data and response taken at the handshake
    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        bit ar_hs;
        bit r_hs;
        int n;
        @(posedge clk_i);
        araddr_o <= a;
        {arvalid_o, rready_o} <= 2'b11;
        for (n = 0; n < 200; n++) begin
            @(negedge clk_i);
            ar_hs = arvalid_o && arready_i;
            r_hs = rready_o && rvalid_i;
            d = rdata_i;
            r = rresp_i;
            @(posedge clk_i);
            if (ar_hs) arvalid_o <= 1'b0;
            if (r_hs) rready_o <= 1'b0;
            if (r_hs) break;
        end
        if (n == 200) hung = 1;
    endtask : rd
endmodule : clkdiv_host_model

//--- rtl/clkdiv_counter.sv
// clkdiv_counter: one divided-clock tick generator with boundary-safe
// switching of enable and terminal count.
// assumes en_i and tc_i stay stable while a load is pending.
`timescale 1ns/1ps
module clkdiv_counter #(
    parameter logic EN_RST = 1'b1,
    parameter logic [5:0] TC_RST = 6'h00
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // settings
    input wire logic en_i,
    input wire logic [5:0] tc_i,
    input wire logic load_i,
    // outputs
    output logic tick_o,
    output logic pend_o
);
    import clkdiv_pkg::*;

    logic en_cur_q, en_cur_d; // running enable
    logic [5:0] tc_cur_q, tc_cur_d; // running terminal count
    logic [5:0] cnt_q, cnt_d; // phase counter
    logic pend_q, pend_d; // ratio change waiting for boundary
    logic tick_q, tick_d; // one pulse per output period
    logic boundary; // end of period or stopped

    // next-state: settings only switch at an output boundary
    always_comb begin
        boundary = !en_cur_q || (cnt_q == tc_cur_q);
        en_cur_d = en_cur_q;
        tc_cur_d = tc_cur_q;
        pend_d = pend_q || load_i;
        tick_d = en_cur_q && (cnt_q == tc_cur_q);
        cnt_d = en_cur_q ? cnt_q + 6'h01 : 6'h00;
        if (boundary) begin
            en_cur_d = en_i;
            cnt_d = 6'h00;
            if (pend_q) begin
                tc_cur_d = tc_i;
                pend_d = load_i;
            end
        end
    end

    // register stage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            en_cur_q <= EN_RST;
            tc_cur_q <= TC_RST;
            cnt_q <= 6'h00;
            pend_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            en_cur_q <= en_cur_d;
            tc_cur_q <= tc_cur_d;
            cnt_q <= cnt_d;
            pend_q <= pend_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;
    assign pend_o = pend_q;

    // a stopped divider emits no tick
    a_stopped_no_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        !en_cur_q |=> !tick_q) else $error("tick while divider stopped");
    // count never passes the terminal count
    a_count_in_range: assert property (@(posedge clk_i) disable iff (rst_i)
        cnt_q <= tc_cur_q) else $error("divider count past terminal");
    // a new count is taken only at a boundary
    a_switch_on_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        !$stable(tc_cur_q) |-> $past(boundary))
        else $error("ratio switched mid-period");
endmodule : clkdiv_counter

//--- rtl/clkdiv_ctrl.sv
// clkdiv_ctrl: reference pre-divider, system clock four and five dividers and
// the ratio-apply (go) command, all behind an axi4-lite slave.
// assumes the reference clock is the system clock; outputs are tick strobes.
`timescale 1ns/1ps
module clkdiv_ctrl (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    // axi4-lite write address and data
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] AWADDR_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    // axi4-lite write response
    output logic BVALID_O,
    input wire logic BREADY_I,
    output logic [1:0] BRESP_O,
    // axi4-lite read
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    input wire logic [31:0] ARADDR_I,
    output logic RVALID_O,
    input wire logic RREADY_I,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    // divided clock strobes and status
    output logic REFERENCE_PREDIVIDER_O,
    output logic SYSTEM_CLOCK_FOUR_O,
    output logic SYSTEM_CLOCK_FIVE_O,
    output logic APPLY_IN_PROGRESS_O
);
    import clkdiv_pkg::*;

    // write channel state
    logic aw_have_q, aw_have_d; // address held
    logic [31:0] aw_addr_q, aw_addr_d;
    logic w_have_q, w_have_d; // data held
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    // read channel state
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic arready_q, arready_d;
    // software-visible settings
    div_cfg_t reference_predivider_q, reference_predivider_d;
    div_cfg_t div4_q, div4_d;
    div_cfg_t div5_q, div5_d;
    logic go_cmd_q, go_cmd_d; // command bit as read back
    logic [1:0] chg_q, chg_d; // changed flags, [0] four, [1] five
    // apply sequencer
    go_state_t go_q, go_d;
    logic [1:0] snap_q, snap_d; // clocks chosen at start
    logic busy_q, busy_d;
    // decode helpers
    logic wr_fire; // a write lands this cycle
    logic go_start; // write of one to the command bit
    logic go_zero; // write of zero to the command bit
    logic reference_predivider_load;
    logic [1:0] post_load;
    logic [1:0] post_pend;
    logic [31:0] rd_word;
    logic rd_hit;
    logic [5:0] tc4, tc5;
    logic reference_predivider_tick, four_tick, five_tick;

    // merge byte-enabled write data into a divider setting
    function automatic div_cfg_t merge_cfg(input div_cfg_t old, input logic [31:0] d,
                                           input logic [3:0] s);
        div_cfg_t r;
        r = old;
        if (s[1]) begin
            r.en = d[EN_BIT];
        end
        if (s[0]) begin
            r.ratio = d[RATIO_MSB:0];
        end
        return r;
    endfunction : merge_cfg

    // axi write path and register writes
    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d = w_have_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q && !BREADY_I;
        bresp_d = bresp_q;
        reference_predivider_d = reference_predivider_q;
        div4_d = div4_q;
        div5_d = div5_q;
        go_cmd_d = go_cmd_q;
        go_start = 1'b0;
        go_zero = 1'b0;
        reference_predivider_load = 1'b0;
        if (AWVALID_I && awready_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = AWADDR_I;
        end
        if (WVALID_I && wready_q) begin
            w_have_d = 1'b1;
            w_data_d = WDATA_I;
            w_strb_d = WSTRB_I;
        end
        wr_fire = aw_have_q && w_have_q && !bvalid_q;
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
            case (aw_addr_q)
                ADDR_REFERENCE_PREDIVIDER: begin
                    reference_predivider_d = merge_cfg(reference_predivider_q, w_data_q, w_strb_q);
                    reference_predivider_load = 1'b1;
                end
                ADDR_DIV4: begin
                    div4_d = merge_cfg(div4_q, w_data_q, w_strb_q);
                end
                ADDR_DIV5: begin
                    div5_d = merge_cfg(div5_q, w_data_q, w_strb_q);
                end
                ADDR_GO_CMD: begin
                    if (w_strb_q[0] && w_data_q[GO_BIT]) begin
                        go_cmd_d = 1'b1;
                        go_start = 1'b1;
                    end else if (w_strb_q[0]) begin
                        go_cmd_d = 1'b0;
                        go_zero = 1'b1;
                    end
                end
                ADDR_GO_STAT, ADDR_CHANGED: begin
                    bresp_d = RESP_OKAY; // read-only, write ignored
                end
                default: begin
                    bresp_d = RESP_DECERR;
                end
            endcase
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
    end

    // read mux, reserved bits zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (ARADDR_I)
            ADDR_REFERENCE_PREDIVIDER: begin
                rd_word[EN_BIT] = reference_predivider_q.en;
                rd_word[RATIO_MSB:0] = reference_predivider_q.ratio;
            end
            ADDR_DIV4: begin
                rd_word[EN_BIT] = div4_q.en;
                rd_word[RATIO_MSB:0] = div4_q.ratio;
            end
            ADDR_DIV5: begin
                rd_word[EN_BIT] = div5_q.en;
                rd_word[RATIO_MSB:0] = div5_q.ratio;
            end
            ADDR_GO_CMD: begin
                rd_word[GO_BIT] = go_cmd_q;
            end
            ADDR_GO_STAT: begin
                rd_word[STAT_BIT] = busy_q;
            end
            ADDR_CHANGED: begin
                rd_word[CHG4_BIT] = chg_q[0];
                rd_word[CHG5_BIT] = chg_q[1];
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
        rvalid_d = rvalid_q && !RREADY_I;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (ARVALID_I && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d = rd_word;
            rresp_d = rd_hit ? RESP_OKAY : RESP_DECERR;
        end
        arready_d = !rvalid_d;
    end

    // apply sequencer and changed flags
    always_comb begin
        go_d = go_q;
        snap_d = snap_q;
        busy_d = busy_q;
        chg_d = chg_q;
        post_load = 2'b00;
        case (go_q)
            GO_IDLE: begin
                if (go_start) begin
                    go_d = GO_LOAD;
                    snap_d = chg_q;
                    busy_d = 1'b1;
                end
            end
            GO_LOAD: begin
                post_load = snap_q;
                go_d = GO_WAIT;
            end
            GO_WAIT: begin
                if ((post_pend & snap_q) == 2'b00) begin
                    go_d = GO_IDLE;
                    busy_d = 1'b0;
                    chg_d = chg_q & ~snap_q;
                end
            end
            default: begin
                go_d = GO_IDLE;
                busy_d = 1'b0;
            end
        endcase
        // a ratio write landing with the clear wins
        if (wr_fire && aw_addr_q == ADDR_DIV4 && div4_d.ratio != div4_q.ratio) begin
            chg_d[0] = 1'b1;
        end
        if (wr_fire && aw_addr_q == ADDR_DIV5 && div5_d.ratio != div5_q.ratio) begin
            chg_d[1] = 1'b1;
        end
    end

    // all state registers
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 32'h0000_0000;
            w_have_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
            reference_predivider_q <= '{en: REFERENCE_PREDIVIDER_EN_RST, ratio: REFERENCE_PREDIVIDER_RATIO_RST};
            div4_q <= '{en: DIV4_EN_RST, ratio: DIV4_RATIO_RST};
            div5_q <= '{en: DIV5_EN_RST, ratio: DIV5_RATIO_RST};
            go_cmd_q <= 1'b0;
            chg_q <= 2'b00;
            go_q <= GO_IDLE;
            snap_q <= 2'b00;
            busy_q <= 1'b0;
        end else begin
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q <= w_have_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            arready_q <= arready_d;
            reference_predivider_q <= reference_predivider_d;
            div4_q <= div4_d;
            div5_q <= div5_d;
            go_cmd_q <= go_cmd_d;
            chg_q <= chg_d;
            go_q <= go_d;
            snap_q <= snap_d;
            busy_q <= busy_d;
        end
    end

    // divide codes to terminal counts
    assign tc4 = {div4_q.ratio, 1'b1}; // terminal count 2*code+1, period 2*code+2
    assign tc5 = {1'b0, div5_q.ratio};

    // pre-divider follows its register directly, code plus one
    clkdiv_counter #(.EN_RST(REFERENCE_PREDIVIDER_EN_RST), .TC_RST(REFERENCE_PREDIVIDER_TC_RST)) u_reference_predivider (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .en_i(reference_predivider_q.en),
        .tc_i({1'b0, reference_predivider_q.ratio}),
        .load_i(reference_predivider_load),
        .tick_o(reference_predivider_tick),
        .pend_o()
    );
    // system clock four, ratio taken only on apply
    clkdiv_counter #(.EN_RST(DIV4_EN_RST), .TC_RST(DIV4_TC_RST)) u_div4 (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .en_i(div4_q.en),
        .tc_i(tc4),
        .load_i(post_load[0]),
        .tick_o(four_tick),
        .pend_o(post_pend[0])
    );
    // system clock five, ratio taken only on apply
    clkdiv_counter #(.EN_RST(DIV5_EN_RST), .TC_RST(DIV5_TC_RST)) u_div5 (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .en_i(div5_q.en),
        .tc_i(tc5),
        .load_i(post_load[1]),
        .tick_o(five_tick),
        .pend_o(post_pend[1])
    );

    // bus and status outputs, all registered
    assign AWREADY_O = awready_q;
    assign WREADY_O = wready_q;
    assign BVALID_O = bvalid_q;
    assign BRESP_O = bresp_q;
    assign ARREADY_O = arready_q;
    assign RVALID_O = rvalid_q;
    assign RDATA_O = rdata_q;
    assign RRESP_O = rresp_q;
    assign REFERENCE_PREDIVIDER_O = reference_predivider_tick;
    assign SYSTEM_CLOCK_FOUR_O = four_tick;
    assign SYSTEM_CLOCK_FIVE_O = five_tick;
    assign APPLY_IN_PROGRESS_O = busy_q;

    // apply phases
    sequence s_start;
        go_q == GO_IDLE && go_start;
    endsequence
    sequence s_running;
        busy_q && go_q != GO_IDLE;
    endsequence

    a_go_starts: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        s_start |=> s_running ##1 go_q == GO_WAIT) else $error("apply did not start");
    a_go_bit_holds: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        go_cmd_q && !go_zero |=> go_cmd_q) else $error("command bit dropped");
    a_zero_no_effect: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        go_zero && go_q == GO_IDLE |=> !go_cmd_q && $stable(go_q) && $stable(busy_q))
        else $error("zero write disturbed apply");
    a_flag_on_change: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        wr_fire && aw_addr_q == ADDR_DIV5 && div5_d.ratio != div5_q.ratio |=> chg_q[1])
        else $error("changed flag not set");
    a_only_flagged: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (post_load & ~chg_q) == 2'b00) else $error("unflagged clock reloaded");
    a_done_clears: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        go_q == GO_WAIT && (post_pend & snap_q) == 2'b00 |=> !busy_q && go_q == GO_IDLE)
        else $error("apply did not finish");
    a_status_idle: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        busy_q == (go_q != GO_IDLE)) else $error("status bit disagrees with sequencer");
    a_reserved_zero: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        rvalid_q |-> rdata_q[31:16] == 16'h0000 && rdata_q[14:5] == 10'h000)
        else $error("reserved bits read nonzero");
    a_div4_count: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        tc4 == 6'({div4_q.ratio, 1'b0}) + 6'h01) else $error("divider four count wrong");
endmodule : clkdiv_ctrl

//--- rtl/clkdiv_pkg.sv
// clkdiv_pkg: register map, field layout, reset values and types for the
// clock divider and ratio-apply control block.
// assumes a 32-bit axi4-lite register bus and one 100 mhz clock.
package clkdiv_pkg;
    // register byte addresses
    localparam logic [31:0] ADDR_REFERENCE_PREDIVIDER = 32'h029a_0114;
    localparam logic [31:0] ADDR_GO_CMD = 32'h029a_0138;
    localparam logic [31:0] ADDR_GO_STAT = 32'h029a_013c;
    localparam logic [31:0] ADDR_CHANGED = 32'h029a_0144;
    localparam logic [31:0] ADDR_DIV4 = 32'h029a_0160;
    localparam logic [31:0] ADDR_DIV5 = 32'h029a_0164;
    // field positions
    localparam int EN_BIT = 15;
    localparam int RATIO_MSB = 4;
    localparam int GO_BIT = 0;
    localparam int STAT_BIT = 0;
    localparam int CHG4_BIT = 3;
    localparam int CHG5_BIT = 4;
    // widths
    localparam int RATIO_W = 5;
    localparam int TC_W = 6;
    // values after reset
    localparam logic REFERENCE_PREDIVIDER_EN_RST = 1'b1;
    localparam logic [4:0] REFERENCE_PREDIVIDER_RATIO_RST = 5'h02;
    localparam logic DIV4_EN_RST = 1'b1;
    localparam logic [4:0] DIV4_RATIO_RST = 5'h03;
    localparam logic DIV5_EN_RST = 1'b1;
    localparam logic [4:0] DIV5_RATIO_RST = 5'h03;
    // terminal counts matching the reset ratios
    localparam logic [5:0] REFERENCE_PREDIVIDER_TC_RST = 6'h02;
    localparam logic [5:0] DIV4_TC_RST = 6'h07;
    localparam logic [5:0] DIV5_TC_RST = 6'h03;
    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    // one divider setting: enable plus ratio code
    typedef struct packed {
        logic en;
        logic [RATIO_W-1:0] ratio;
    } div_cfg_t;

    // ratio-apply sequencer, idle -> load -> wait -> idle, gray except wait -> idle
    typedef enum logic [1:0] {
        GO_IDLE = 2'b00,
        GO_LOAD = 2'b01,
        GO_WAIT = 2'b11
    } go_state_t;
endpackage : clkdiv_pkg
